/* riss_map.vh */
/*
  Address map, field layout, select codes and reset values for the
  remappable input select block.
  Assumes byte addressing on a 32-bit Avalon-MM slave port.
*/
`ifndef RISS_MAP_VH
`define RISS_MAP_VH

// bus geometry
`define RISS_ADDR_W 7
`define RISS_IDX_MSB 6
`define RISS_IDX_LSB 2
`define RISS_DATA_W 32

// register indices, byte address is index times four
`define RISS_REG_EXTIRQ1 5'h00
`define RISS_REG_EXTIRQ2 5'h01
`define RISS_REG_T2CLK 5'h02
`define RISS_REG_CAP12 5'h03
`define RISS_REG_CAP34 5'h04
`define RISS_REG_CMPFLT 5'h05
`define RISS_REG_PWMFLT 5'h06
`define RISS_REG_QPHASE 5'h07
`define RISS_REG_QIDXHOME 5'h08
`define RISS_REG_SER1RX 5'h09
`define RISS_REG_SER2RX 5'h0A
`define RISS_REG_SPIDC 5'h0B
`define RISS_REG_SPISEL 5'h0C
`define RISS_REG_CANRX 5'h0D
`define RISS_REG_PWMSYNC 5'h0E
`define RISS_REG_DTC1 5'h0F
`define RISS_REG_DTC23 5'h10
`define RISS_REG_LOCK 5'h11

// field layout inside a select register
`define RISS_SEL_W 7
`define RISS_LO_MSB 6
`define RISS_LO_LSB 0
`define RISS_HI_MSB 14
`define RISS_HI_LSB 8
`define RISS_SEL_RESET 7'h00
`define RISS_FIELDS 24
`define RISS_NO_FIELD 5'h1F

// lock control
`define RISS_LOCK_BIT 0
`define RISS_UNLOCK_KEY 16'hA55A

// select codes
`define RISS_CODE_GROUND 7'h00
`define RISS_CODE_CMP_FIRST 7'h01
`define RISS_CODE_CMP_LAST 7'h04
`define RISS_CODE_TRIG_A 7'h06
`define RISS_CODE_TRIG_B 7'h07
`define RISS_CODE_FQ_INDEX 7'h08
`define RISS_CODE_FQ_HOME 7'h09

// codes that name an implemented remappable pin
`define RISS_PIN_MASK 128'h03C00003_C0000000_07F8FFFF_1B100000
`define RISS_PINS 128

`endif

/* riss_input_select.v */
/*
  Remappable input select: one 7-bit source select per remappable
  peripheral input, programmed over Avalon-MM, routing a pin, ground
  or an internal virtual source to each peripheral input.
  Assumes pin levels arrive asynchronously, virtual sources and analog
  enables come from logic on the same clock, byte addressing.
*/
`timescale 1ns/1ps
`include "riss_map.vh"

// What this block does
// [R1] each peripheral input owns a select field naming its source
// [R2] selects are seven bits; an implemented pin code n connects remappable pin n
// [R3] code zero grounds the input; pin codes pick that pin number
// [R4] codes 1-4 comparators, 6-7 trigger outputs, 8-9 filtered quadrature
// [R5] fault one select value one feeds comparator one to fault one
// [R6] only implemented pin codes route; unimplemented codes give zero
// [R7] twenty-four peripheral inputs are selectable
// [R8] input-only and full remappable pins both serve as input sources
// [R9] no default pin; inputs float to ground until programmed
// [R10] fixed-pin peripherals keep their own pins, untouched here
// [R11] a mapped input reads the pin over any port or digital use
// [R12] an active analog function on a pin blocks the digital input
// [R13] input selects are separate from any output mapping registers
// [R14] a lock bit guards the selects against spurious writes
// [R15] bus and analog inputs are not routed through this block; PWM fault and sync inputs are
// [R16] software enables quadrature filter before picking filtered sources
// [R17] up to two fields per register at bits 6:0 and 14:8, others zero
// [R18] every select clears to zero on reset
// [R19] no lockout between selects; many inputs may share one pin
module riss_input_select (
  input wire clock,
  input wire srst,
  input wire [`RISS_ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [`RISS_DATA_W-1:0] writedata,
  input wire [3:0] byteenable,
  output wire [`RISS_DATA_W-1:0] readdata,
  output wire waitrequest,
  input wire [`RISS_PINS-1:0] remapPin,
  input wire [`RISS_PINS-1:0] pinAnalogOn,
  input wire [3:0] comparatorOutput,
  input wire triggerGenOutputA,
  input wire triggerGenOutputB,
  input wire filteredQuadIndex,
  input wire filteredQuadHome,
  output wire externalIrqOne,
  output wire externalIrqTwo,
  output wire timer2ExtClock,
  output wire captureInOne,
  output wire captureInTwo,
  output wire captureInThree,
  output wire captureInFour,
  output wire compareFaultA,
  output wire pwmFaultOne,
  output wire pwmFaultTwo,
  output wire quadPhaseA,
  output wire quadPhaseB,
  output wire quadIndex,
  output wire quadHome,
  output wire serialOneReceive,
  output wire serialTwoReceive,
  output wire spiTwoDataIn,
  output wire spiTwoClockIn,
  output wire spiTwoSelectIn,
  output wire canReceive,
  output wire pwmSyncIn,
  output wire deadtimeCompInOne,
  output wire deadtimeCompInTwo,
  output wire deadtimeCompInThree
);

  // select storage, one entry per peripheral input
  reg [`RISS_SEL_W-1:0] sel_q [0:`RISS_FIELDS-1];
  reg lock_q;
  reg waitrequest_q;
  reg [`RISS_DATA_W-1:0] readdata_q;
  reg [`RISS_PINS-1:0] pinMeta_q;
  reg [`RISS_PINS-1:0] pinSync_q;
  reg [`RISS_FIELDS-1:0] periphIn_q;
  reg [`RISS_FIELDS-1:0] periphIn_d;
  wire [4:0] regIdx;
  wire [4:0] wrLo;
  wire [4:0] wrHi;
  wire wrAccept;
  integer i;
  integer j;

  assign regIdx = address[`RISS_IDX_MSB:`RISS_IDX_LSB];

  // low field of a register, field order follows the peripheral list
  function [4:0] loField;
    input [4:0] idx;
    begin
      case (idx) // [R1] [R7]
        `RISS_REG_EXTIRQ1: loField = 5'h00;
        `RISS_REG_EXTIRQ2: loField = 5'h01;
        `RISS_REG_T2CLK: loField = 5'h02;
        `RISS_REG_CAP12: loField = 5'h03;
        `RISS_REG_CAP34: loField = 5'h05;
        `RISS_REG_CMPFLT: loField = 5'h07;
        `RISS_REG_PWMFLT: loField = 5'h08;
        `RISS_REG_QPHASE: loField = 5'h0A;
        `RISS_REG_QIDXHOME: loField = 5'h0C;
        `RISS_REG_SER1RX: loField = 5'h0E;
        `RISS_REG_SER2RX: loField = 5'h0F;
        `RISS_REG_SPIDC: loField = 5'h10;
        `RISS_REG_SPISEL: loField = 5'h12;
        `RISS_REG_CANRX: loField = 5'h13;
        `RISS_REG_PWMSYNC: loField = 5'h14;
        `RISS_REG_DTC1: loField = 5'h15;
        `RISS_REG_DTC23: loField = 5'h16;
        default: loField = `RISS_NO_FIELD;
      endcase
    end
  endfunction

  // high field of a register, only shared registers have one
  function [4:0] hiField;
    input [4:0] idx;
    begin
      case (idx) // [R17]
        `RISS_REG_CAP12: hiField = 5'h04;
        `RISS_REG_CAP34: hiField = 5'h06;
        `RISS_REG_PWMFLT: hiField = 5'h09;
        `RISS_REG_QPHASE: hiField = 5'h0B;
        `RISS_REG_QIDXHOME: hiField = 5'h0D;
        `RISS_REG_SPIDC: hiField = 5'h11;
        `RISS_REG_DTC23: hiField = 5'h17;
        default: hiField = `RISS_NO_FIELD;
      endcase
    end
  endfunction

  // read word for a register index, unused bits zero
  function [`RISS_DATA_W-1:0] readWord;
    input [4:0] idx;
    reg [4:0] lo;
    reg [4:0] hi;
    begin
      lo = loField(idx);
      hi = hiField(idx);
      readWord = {`RISS_DATA_W{1'b0}};
      if (lo != `RISS_NO_FIELD)
        readWord[`RISS_LO_MSB:`RISS_LO_LSB] = sel_q[lo]; // [R17]
      if (hi != `RISS_NO_FIELD)
        readWord[`RISS_HI_MSB:`RISS_HI_LSB] = sel_q[hi]; // [R17]
      if (idx == `RISS_REG_LOCK)
        readWord[`RISS_LOCK_BIT] = lock_q;
    end
  endfunction

  // source for one select code
  function routeSource;
    input [`RISS_SEL_W-1:0] code;
    reg [`RISS_SEL_W-1:0] cmpIdx;
    reg [`RISS_PINS-1:0] implMask;
    begin
      cmpIdx = code - `RISS_CODE_CMP_FIRST;
      implMask = `RISS_PIN_MASK;
      if (code == `RISS_CODE_GROUND) begin
        routeSource = 1'b0; // [R3] [R9]
      end else if (code >= `RISS_CODE_CMP_FIRST &&
                   code <= `RISS_CODE_CMP_LAST) begin
        routeSource = comparatorOutput[cmpIdx[1:0]]; // [R4] [R5]
      end else if (code == `RISS_CODE_TRIG_A) begin
        routeSource = triggerGenOutputA; // [R4]
      end else if (code == `RISS_CODE_TRIG_B) begin
        routeSource = triggerGenOutputB; // [R4]
      end else if (code == `RISS_CODE_FQ_INDEX) begin
        routeSource = filteredQuadIndex; // [R4] [R16]
      end else if (code == `RISS_CODE_FQ_HOME) begin
        routeSource = filteredQuadHome; // [R4] [R16]
      end else if (implMask[code]) begin
        // pin n by its number, input-only or full pin alike
        routeSource = pinSync_q[code] & ~pinAnalogOn[code]; // [R2] [R8] [R12]
      end else begin
        routeSource = 1'b0; // [R6]
      end
    end
  endfunction

  // write decode: lock guards every select field
  assign wrLo = loField(regIdx);
  assign wrHi = hiField(regIdx);
  assign wrAccept = write & ~read & ~waitrequest_q;

  // avalon slave: one wait cycle, then write or read completes
  always @(posedge clock) begin
    if (srst) begin
      waitrequest_q <= 1'b1;
      readdata_q <= {`RISS_DATA_W{1'b0}};
      lock_q <= 1'b0;
      for (i = 0; i < `RISS_FIELDS; i = i + 1)
        sel_q[i] <= `RISS_SEL_RESET; // [R18] [R9]
    end else begin
      waitrequest_q <= 1'b1;
      if ((read | write) && waitrequest_q) begin
        waitrequest_q <= 1'b0;
        if (read)
          readdata_q <= readWord(regIdx);
        else
          readdata_q <= {`RISS_DATA_W{1'b0}};
      end
      if (wrAccept) begin
        // selects are independent, any combination is kept
        if (!lock_q && wrLo != `RISS_NO_FIELD && byteenable[0])
          sel_q[wrLo] <= writedata[`RISS_LO_MSB:`RISS_LO_LSB]; // [R19]
        if (!lock_q && wrHi != `RISS_NO_FIELD && byteenable[1])
          sel_q[wrHi] <= writedata[`RISS_HI_MSB:`RISS_HI_LSB]; // [R19]
        // key unlocks, setting the lock bit locks
        if (regIdx == `RISS_REG_LOCK && byteenable[0] && byteenable[1]) begin
          if (writedata[15:0] == `RISS_UNLOCK_KEY)
            lock_q <= 1'b0; // [R14]
          else if (writedata[`RISS_LOCK_BIT])
            lock_q <= 1'b1; // [R14]
        end
      end
    end
  end

  // two-stage synchroniser for the pin levels
  always @(posedge clock) begin
    if (srst) begin
      pinMeta_q <= {`RISS_PINS{1'b0}};
      pinSync_q <= {`RISS_PINS{1'b0}};
    end else begin
      pinMeta_q <= remapPin;
      pinSync_q <= pinMeta_q;
    end
  end

  // per-peripheral source mux, pin wins over port and other digital use
  always @* begin
    periphIn_d = {`RISS_FIELDS{1'b0}};
    for (j = 0; j < `RISS_FIELDS; j = j + 1)
      periphIn_d[j] = routeSource(sel_q[j]); // [R1] [R11] [R19]
  end

  // registered peripheral inputs
  always @(posedge clock) begin
    if (srst)
      periphIn_q <= {`RISS_FIELDS{1'b0}};
    else
      periphIn_q <= periphIn_d;
  end

  // bus outputs straight from flops
  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;

  // peripheral inputs; output mapping lives elsewhere
  // fixed-pin peripherals and analog inputs never pass through here
  assign externalIrqOne = periphIn_q[0]; // [R13] [R10] [R15]
  assign externalIrqTwo = periphIn_q[1];
  assign timer2ExtClock = periphIn_q[2];
  assign captureInOne = periphIn_q[3];
  assign captureInTwo = periphIn_q[4];
  assign captureInThree = periphIn_q[5];
  assign captureInFour = periphIn_q[6];
  assign compareFaultA = periphIn_q[7];
  assign pwmFaultOne = periphIn_q[8];
  assign pwmFaultTwo = periphIn_q[9];
  assign quadPhaseA = periphIn_q[10];
  assign quadPhaseB = periphIn_q[11];
  assign quadIndex = periphIn_q[12];
  assign quadHome = periphIn_q[13];
  assign serialOneReceive = periphIn_q[14];
  assign serialTwoReceive = periphIn_q[15];
  assign spiTwoDataIn = periphIn_q[16];
  assign spiTwoClockIn = periphIn_q[17];
  assign spiTwoSelectIn = periphIn_q[18];
  assign canReceive = periphIn_q[19];
  assign pwmSyncIn = periphIn_q[20];
  assign deadtimeCompInOne = periphIn_q[21];
  assign deadtimeCompInTwo = periphIn_q[22];
  assign deadtimeCompInThree = periphIn_q[23];

endmodule

/* riss_checker.sv */
/* checker for the remappable input select block
   assumes a bind onto riss_input_select and byteenable held at all ones */
`timescale 1ns/1ps
module riss_checker (
  input wire clock,
  input wire srst,
  input wire [6:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire [3:0] comparatorOutput,
  input wire triggerGenOutputA,
  input wire filteredQuadHome,
  input wire pwmFaultOne
);
  reg [6:0] fltSel_q;
  reg lock_q;
  wire done = write && !waitrequest;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // shadow of the fault one select and of the lock
  always @(posedge clock) begin
    if (srst) begin
      fltSel_q <= 7'h00;
      lock_q <= 1'b0;
    end else if (done && address[6:2] == 5'h11) begin
      lock_q <= (writedata[15:0] != 16'hA55A) && (writedata[0] || lock_q);
    end else if (done && address[6:2] == 5'h06 && !lock_q) begin
      fltSel_q <= writedata[6:0];
    end
  end
  property p_rst;
    disable iff (1'b0) srst |=> waitrequest && readdata == 32'h0 && !pwmFaultOne;
  endproperty
  property p_ack;
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  property p_pad;
    read && !waitrequest |-> readdata[31:15] == 17'h0 && !readdata[7];
  endproperty
  property p_gnd;
    fltSel_q == 7'h00 |=> !pwmFaultOne;
  endproperty
  property p_cmp;
    fltSel_q == 7'h01 |=> pwmFaultOne == $past(comparatorOutput[0]);
  endproperty
  property p_trig;
    fltSel_q == 7'h06 |=> pwmFaultOne == $past(triggerGenOutputA);
  endproperty
  property p_fq;
    fltSel_q == 7'h09 |=> pwmFaultOne == $past(filteredQuadHome);
  endproperty
  property p_unimpl;
    fltSel_q == 7'h05 |=> !pwmFaultOne;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_ack: assert property (p_ack) else $error("bus answer late");
  a_pad: assert property (p_pad) else $error("pad bits set");
  a_gnd: assert property (p_gnd) else $error("ground code");
  a_cmp: assert property (p_cmp) else $error("comparator");
  a_trig: assert property (p_trig) else $error("trigger");
  a_fq: assert property (p_fq) else $error("filtered home");
  a_unimpl: assert property (p_unimpl) else $error("code five");
  c_wr: cover property (done);
  c_rd: cover property (read && !waitrequest);
  c_cmp: cover property (fltSel_q == 7'h01 && comparatorOutput[0]);
endmodule
bind riss_input_select riss_checker u_chk (.clock(clock), .srst(srst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest),
  .comparatorOutput(comparatorOutput), .triggerGenOutputA(triggerGenOutputA),
  .filteredQuadHome(filteredQuadHome), .pwmFaultOne(pwmFaultOne));

/* riss_far_side.sv */
/* far side: remappable pin levels and internal virtual sources
   assumes the bench sets pin and analog levels */
`timescale 1ns/1ps
module riss_far_side (
  input wire clock,
  input wire [127:0] pinLevel,
  input wire [127:0] analogMask,
  output wire [127:0] remapPin,
  output wire [127:0] pinAnalogOn,
  output wire [3:0] comparatorOutput,
  output wire triggerGenOutputA,
  output wire triggerGenOutputB,
  output wire filteredQuadIndex,
  output wire filteredQuadHome
);
  reg [7:0] src_q = 8'h00;
  // pins of both kinds and their analog enables
  assign remapPin = pinLevel;
  assign pinAnalogOn = analogMask;
  // virtual source word steps by 0x25 every cycle so a stuck route shows
  // filtered index and home stand for an enabled quadrature filter
  always @(posedge clock) begin
    src_q <= src_q + 8'h25;
  end
  assign {filteredQuadHome, filteredQuadIndex, triggerGenOutputB,
    triggerGenOutputA, comparatorOutput} = src_q;
endmodule

/* riss_input_select_tb.sv */
/* bench for the remappable input select block
   assumes the far-side model and the bound checker */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin \
  error_cnt++; $display("mismatch at %0t got %h expected %h", \
  $time, (a), (e)); end end
module riss_input_select_tb;
  reg clock = 1'b0;
  reg srst = 1'b1;
  reg [6:0] address = 7'h00;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg [127:0] pinLevel = 128'h0;
  reg [127:0] analogMask = 128'h0;
  wire [31:0] readdata;
  wire waitrequest;
  wire [127:0] remapPin;
  wire [127:0] pinAnalogOn;
  wire [3:0] cmpOut;
  wire trigA, trigB, fqIdx, fqHome;
  wire [23:0] per;
  int error_cnt = 0;
  int n_checks = 0;
  int i, k, f;
  logic [9:0] vsrc;
  logic [31:0] expv [0:16];
  // per field: bit 5 upper field, bits 4:0 register index
  logic [5:0] fmap [0:23] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h23, 6'h04,
    6'h24, 6'h05, 6'h06, 6'h26, 6'h07, 6'h27, 6'h08, 6'h28, 6'h09, 6'h0A,
    6'h0B, 6'h2B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h30};
  riss_far_side far (.clock(clock), .pinLevel(pinLevel),
    .analogMask(analogMask), .remapPin(remapPin), .pinAnalogOn(pinAnalogOn),
    .comparatorOutput(cmpOut), .triggerGenOutputA(trigA),
    .triggerGenOutputB(trigB), .filteredQuadIndex(fqIdx),
    .filteredQuadHome(fqHome));
  riss_input_select DUT (.clock(clock), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .remapPin(remapPin),
    .pinAnalogOn(pinAnalogOn), .comparatorOutput(cmpOut),
    .triggerGenOutputA(trigA), .triggerGenOutputB(trigB),
    .filteredQuadIndex(fqIdx), .filteredQuadHome(fqHome),
    .externalIrqOne(per[0]), .externalIrqTwo(per[1]),
    .timer2ExtClock(per[2]), .captureInOne(per[3]), .captureInTwo(per[4]),
    .captureInThree(per[5]), .captureInFour(per[6]),
    .compareFaultA(per[7]), .pwmFaultOne(per[8]), .pwmFaultTwo(per[9]),
    .quadPhaseA(per[10]), .quadPhaseB(per[11]), .quadIndex(per[12]),
    .quadHome(per[13]), .serialOneReceive(per[14]),
    .serialTwoReceive(per[15]), .spiTwoDataIn(per[16]),
    .spiTwoClockIn(per[17]), .spiTwoSelectIn(per[18]),
    .canReceive(per[19]), .pwmSyncIn(per[20]), .deadtimeCompInOne(per[21]),
    .deadtimeCompInTwo(per[22]), .deadtimeCompInThree(per[23]));
  // clock of 100 ns
  initial begin
    forever #50 clock = ~clock;
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [4:0] idx,
      input logic [31:0] wd, output logic [31:0] rdv);
    int n;
    @(posedge clock);
    read <= rd;
    write <= !rd;
    address <= {idx, 2'b00};
    writedata <= wd;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      $display("mismatch at %0t bus hang", $time);
      stop_test();
    end
  endtask
  task automatic wr(input logic [4:0] idx, input logic [31:0] wd);
    logic [31:0] v;
    bus(1'b0, idx, wd, v);
  endtask
  task automatic rd(input logic [4:0] idx, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b1, idx, 32'h0, v);
    `CHK(v, e)
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    for (i = 0; i < 17; i++) rd(i[4:0], 32'h0);
    `CHK(per, 24'h0)
    for (i = 0; i < 17; i++) expv[i] = 32'h0;
    for (f = 0; f < 24; f++)
      expv[fmap[f][4:0]] |= fmap[f][5] ? 32'h7F00 : 32'h7F;
    // register zero first: index 0x11 in the sweep sets the lock
    wr(5'h00, 32'hFFFF_FFFF);
    for (i = 0; i < 18; i++) wr(i[4:0] + 5'h1, 32'hFFFF_FFFF);
    wr(5'h11, 32'h0000_A55A);
    for (i = 0; i < 17; i++) rd(i[4:0], expv[i]);
    rd(5'h12, 32'h0);
    for (i = 0; i < 17; i++) wr(i[4:0], 32'h0000_1814);
    for (k = 0; k < 2; k++) begin
      pinLevel <= (k == 0) ? (128'h1 << 20) : (128'h1 << 24);
      settle();
      for (f = 0; f < 24; f++) `CHK(per[f], fmap[f][5] == k[0])
    end
    analogMask <= 128'h1 << 20;
    pinLevel <= 128'h1 << 20;
    settle();
    `CHK(per, 24'h0)
    analogMask <= 128'h0;
    pinLevel <= ~128'h0;
    for (i = 0; i < 17; i++) wr(i[4:0], 32'h0000_0515);
    settle();
    `CHK(per, 24'h0)
    for (k = 0; k < 10; k++) begin
      wr(5'h06, 32'(k));
      @(negedge clock);
      for (i = 0; i < 4; i++) begin
        vsrc = {fqHome, fqIdx, trigB, trigA, 1'b0, cmpOut, 1'b0};
        @(negedge clock);
        `CHK(per[8], vsrc[k])
      end
    end
    wr(5'h11, 32'h1);
    wr(5'h06, 32'h14);
    rd(5'h06, 32'h9);
    rd(5'h11, 32'h1);
    wr(5'h11, 32'h0000_A55A);
    rd(5'h11, 32'h0);
    stop_test();
  end
endmodule
